// ### hdl/twbc_top.v
// two-wire bus controller: master and slave, 7-bit addressing
// assumes open-drain pads resolved outside; pins are asynchronous
`timescale 1ns/1ps
`include "twbc_regs.vh"
// Summary of operation
// R1 - only seven-bit slave addresses are used in every role
// R2 - acts as master transmitter, master receiver, slave receiver or transmitter
// R3 - masters arbitrate on data; only one keeps the bus
// R4 - clock low period is set by slowest party holding it low
// R5 - standard 100 kbit/s or fast 400 kbit/s clock rate; the master times a bit as 3*qlen+5 clocks, about 132 or 510 kbit/s
// R6 - lines driven only open-drain; low wins, high when all release
// R7 - bus free when data and clock are both high
// R8 - busy from start to stop; no master transfer begins while busy
// R9 - the master makes every clock pulse, start and stop
// R10 - without a start, stay unaddressed slave driving neither line
// R11 - compare address byte with own address and enabled general call
// R12 - own address bit 0 enables general call recognition
// R13 - matching address raises an interrupt request
// R14 - nine clocks per byte: eight data msb first then acknowledge
// R15 - any byte count per transfer; receiver acks each byte
// R16 - transmitter releases data after eighth fall, samples ninth pulse
// R17 - receiver not ready may hold clock low after ninth pulse
// R18 - master waits while clock held low, resumes after release
// R19 - master losing a high data bit stops driving, records loss
// R20 - pads driven through output latches, which must be one first
module twbc_top (
    // clock and reset
    input wire clk,
    input wire rst,
    // core control
    input wire bus_interface_enable,
    input wire [7:0] own_address_register,
    input wire fast_mode,
    input wire pin_latch_sda,
    input wire pin_latch_scl,
    input wire mst_start,
    input wire mst_stop,
    input wire [6:0] mst_addr,
    input wire mst_read,
    input wire [7:0] tx_data,
    input wire tx_ack,
    input wire cpu_ready,
    // core status
    output reg [7:0] rx_data_q,
    output reg byte_done_q,
    output reg ack_rx_q,
    output reg addr_match_q,
    output reg slave_tx_q,
    output reg arb_lost_q,
    output reg bus_busy_q,
    output reg mst_active_q,
    // serial data pin
    input wire serial_data_pin_i,
    output reg serial_data_pin_o,
    output reg serial_data_pin_oe,
    // serial clock pin
    input wire serial_clock_pin_i,
    output reg serial_clock_pin_o,
    output reg serial_clock_pin_oe
);
    // ==================================================
    // states
    localparam S_IDLE = 3'd0;
    localparam S_START = 3'd1;
    localparam S_BIT = 3'd2;
    localparam S_WAIT = 3'd3;
    localparam S_STOP = 3'd4;
    localparam S_SLV = 3'd5;
    localparam [31:0] QS_W = `TWBC_QTR_STD;
    localparam [31:0] QF_W = `TWBC_QTR_FAST;
    localparam [7:0] QS = QS_W[7:0];
    localparam [7:0] QF = QF_W[7:0];

    // ==================================================
    // pin synchronisers
    reg sda_m_q, sda_q, scl_m_q, scl_q, sda_p_q, scl_p_q;
    always @(posedge clk)
    begin
        sda_m_q <= serial_data_pin_i;
        sda_q <= sda_m_q;
        scl_m_q <= serial_clock_pin_i;
        scl_q <= scl_m_q;
        sda_p_q <= sda_q;
        scl_p_q <= scl_q;
    end
    wire scl_rise = scl_q & ~scl_p_q;
    wire scl_fall = ~scl_q & scl_p_q;
    wire start_det = scl_q & scl_p_q & sda_p_q & ~sda_q;
    wire stop_det = scl_q & scl_p_q & ~sda_p_q & sda_q;

    // ==================================================
    // bus free/busy tracking
    always @(posedge clk)
    begin
        if (rst | ~bus_interface_enable)
            bus_busy_q <= 1'b0;
        else if (start_det)
            bus_busy_q <= 1'b1; // R8
        else if (stop_det)
            bus_busy_q <= 1'b0; // R7
    end

    // ==================================================
    // shared state
    reg [2:0] st_q;
    reg [7:0] qcnt_q;
    reg [1:0] ph_q;
    reg [3:0] bit_q;
    reg sda_drv_q, scl_drv_q;
    reg addr_phase_q, mrd_q, stop_pend_q;
    reg sh_load, sh_shift;
    reg [7:0] sh_ld_data;
    wire [7:0] sh_q;
    twbc_shift u_shift (
        .clk(clk),
        .rst(rst),
        .load(sh_load),
        .load_data(sh_ld_data),
        .shift(sh_shift),
        .shift_in(sda_q),
        .data_q(sh_q)
    );
    wire tick = (qcnt_q == 8'h00);
    wire [7:0] qlen = fast_mode ? QF : QS; // R5
    // ack bit index is 8 in both roles
    wire in_ack = (bit_q == `TWBC_BITS_PER_BYTE);
    wire my_tx = mst_active_q ? (addr_phase_q | ~mrd_q) : slave_tx_q;
    wire gc_en = own_address_register[`TWBC_GC_BIT]; // R12
    wire adr_hit = (sh_q[7:1] == own_address_register[7:1]); // R1 R11
    wire gc_hit = gc_en && (sh_q[7:1] == `TWBC_GCALL_ADDR); // R11

    // ==================================================
    // main sequencer
    always @(posedge clk)
    begin
        sh_load <= 1'b0;
        sh_shift <= 1'b0;
        sh_ld_data <= 8'h00;
        byte_done_q <= 1'b0;
        if (rst | ~bus_interface_enable)
        begin
            st_q <= S_IDLE;
            qcnt_q <= 8'h00;
            ph_q <= 2'd0;
            bit_q <= 4'h0;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
            addr_phase_q <= 1'b0;
            mrd_q <= 1'b0;
            stop_pend_q <= 1'b0;
            rx_data_q <= 8'h00;
            ack_rx_q <= 1'b0;
            addr_match_q <= 1'b0;
            slave_tx_q <= 1'b0;
            arb_lost_q <= 1'b0;
            mst_active_q <= 1'b0;
        end
        else
        begin
            qcnt_q <= tick ? qlen - 8'h01 : qcnt_q - 8'h01;
            if (mst_stop)
                stop_pend_q <= 1'b1;
            if (mst_start)
                arb_lost_q <= 1'b0;
            case (st_q)
            S_IDLE:
            begin
                sda_drv_q <= 1'b0; // R10
                scl_drv_q <= 1'b0;
                addr_match_q <= 1'b0;
                slave_tx_q <= 1'b0;
                if (mst_start && !bus_busy_q && scl_q && sda_q) // R8
                begin
                    st_q <= S_START;
                    mst_active_q <= 1'b1;
                    mrd_q <= mst_read;
                    addr_phase_q <= 1'b1;
                    stop_pend_q <= 1'b0;
                    sh_load <= 1'b1;
                    sh_ld_data <= {mst_addr, mst_read}; // R1
                    qcnt_q <= qlen;
                end
                else if (start_det)
                begin
                    st_q <= S_SLV;
                    addr_phase_q <= 1'b1;
                    // the fall ending a start carries no bit
                    bit_q <= 4'hf;
                end
            end
            S_START:
                if (tick)
                begin
                    sda_drv_q <= 1'b1; // R9
                    st_q <= S_BIT;
                    ph_q <= 2'd0;
                    bit_q <= 4'h0;
                end
            S_BIT:
            begin
                // phase 0 low+data, 1 release, 2 high, 3 fall
                if (ph_q == 2'd0 && tick)
                begin
                    scl_drv_q <= 1'b1; // R9
                    if (in_ack)
                        sda_drv_q <= my_tx ? 1'b0 : tx_ack; // R16
                    else
                        sda_drv_q <= my_tx ? ~sh_q[7] : 1'b0; // R14
                    ph_q <= 2'd1;
                end
                else if (ph_q == 2'd1 && tick)
                begin
                    scl_drv_q <= 1'b0;
                    ph_q <= 2'd2;
                end
                else if (ph_q == 2'd2 && scl_q)
                begin
                    // stretched low by a slave holds here
                    qcnt_q <= qlen; // R4 R18
                    ph_q <= 2'd3;
                    if (!sda_drv_q && !sda_q && my_tx && !in_ack)
                    begin
                        arb_lost_q <= 1'b1; // R3 R19
                        sda_drv_q <= 1'b0;
                        scl_drv_q <= 1'b0;
                        mst_active_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                    else if (in_ack)
                        ack_rx_q <= ~sda_q; // R16
                    else
                        sh_shift <= 1'b1;
                end
                else if (ph_q == 2'd3 && tick)
                begin
                    scl_drv_q <= 1'b1;
                    ph_q <= 2'd0;
                    if (in_ack)
                    begin
                        byte_done_q <= 1'b1; // R15
                        rx_data_q <= sh_q;
                        st_q <= S_WAIT;
                        if (my_tx && sda_q)
                            stop_pend_q <= 1'b1;
                    end
                    else
                        bit_q <= bit_q + 4'h1;
                end
            end
            S_WAIT:
            begin
                scl_drv_q <= 1'b1;
                sda_drv_q <= 1'b0;
                addr_phase_q <= 1'b0;
                if (stop_pend_q)
                begin
                    sda_drv_q <= 1'b1;
                    st_q <= S_STOP;
                    qcnt_q <= qlen;
                end
                else if (cpu_ready)
                begin
                    sh_load <= 1'b1;
                    sh_ld_data <= tx_data;
                    bit_q <= 4'h0;
                    st_q <= S_BIT;
                end
            end
            S_STOP:
                if (tick)
                begin
                    if (scl_drv_q)
                        scl_drv_q <= 1'b0;
                    else if (scl_q)
                    begin
                        sda_drv_q <= 1'b0; // R9
                        mst_active_q <= 1'b0;
                        stop_pend_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
            S_SLV:
            begin
                if (stop_det || start_det)
                begin
                    bit_q <= 4'hf;
                    addr_phase_q <= 1'b1;
                    sda_drv_q <= 1'b0;
                    scl_drv_q <= 1'b0;
                    addr_match_q <= 1'b0;
                    slave_tx_q <= 1'b0;
                    if (stop_det)
                        st_q <= S_IDLE;
                end
                else if (scl_rise)
                begin
                    if (in_ack)
                        ack_rx_q <= ~sda_q;
                    else
                        sh_shift <= 1'b1; // R14
                end
                else if (scl_fall)
                begin
                    if (bit_q == 4'hf)
                        bit_q <= 4'h0;
                    else if (in_ack)
                    begin
                        bit_q <= 4'h0;
                        sda_drv_q <= 1'b0;
                        if (slave_tx_q && sda_q)
                            st_q <= S_IDLE;
                        else if (addr_match_q)
                        begin
                            scl_drv_q <= ~cpu_ready; // R17
                            sh_load <= slave_tx_q;
                            sh_ld_data <= tx_data;
                            sda_drv_q <= slave_tx_q & ~tx_data[7];
                        end
                        else
                            st_q <= S_IDLE; // R10
                    end
                    else if (bit_q == 4'h7)
                    begin
                        bit_q <= 4'h8;
                        if (addr_phase_q)
                        begin
                            addr_phase_q <= 1'b0;
                            if (adr_hit || gc_hit)
                            begin
                                addr_match_q <= 1'b1; // R13
                                slave_tx_q <= sh_q[0] & adr_hit; // R2
                                sda_drv_q <= 1'b1;
                            end
                        end
                        else
                        begin
                            rx_data_q <= sh_q;
                            byte_done_q <= 1'b1;
                            sda_drv_q <= ~slave_tx_q & tx_ack; // R15 R16
                        end
                    end
                    else
                    begin
                        bit_q <= bit_q + 4'h1;
                        sda_drv_q <= slave_tx_q & ~sh_q[7];
                    end
                end
                else if (scl_drv_q && cpu_ready)
                    scl_drv_q <= 1'b0; // R18
            end
            default:
                st_q <= S_IDLE;
            endcase
        end
    end

    // ==================================================
    // open-drain pads; latch low forces line low
    always @(posedge clk)
    begin
        if (rst)
        begin
            serial_data_pin_o <= 1'b0;
            serial_data_pin_oe <= 1'b0;
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
        end
        else
        begin
            serial_data_pin_o <= 1'b0; // R6
            serial_clock_pin_o <= 1'b0;
            serial_data_pin_oe <= ~pin_latch_sda |
                (bus_interface_enable & sda_drv_q); // R20
            serial_clock_pin_oe <= ~pin_latch_scl |
                (bus_interface_enable & scl_drv_q); // R20
        end
    end
endmodule // twbc_top

// ### hdl/twbc_regs.vh
// constants for the two-wire bus controller
// assumes inclusion by twbc_top.v and twbc_shift.v only
`ifndef TWBC_REGS_VH
`define TWBC_REGS_VH
// ==================================================
// timing
`define TWBC_CLK_HZ 50000000
`define TWBC_STD_HZ 100000
`define TWBC_FAST_HZ 400000
// quarter-bit counts derived from clock and bit rate
`define TWBC_QTR_STD (`TWBC_CLK_HZ / (4 * `TWBC_STD_HZ))
`define TWBC_QTR_FAST (`TWBC_CLK_HZ / (4 * `TWBC_FAST_HZ))
// ==================================================
// addresses and fields
`define TWBC_GCALL_ADDR 7'h00
`define TWBC_GC_BIT 0
`define TWBC_ADDR_RST 8'h00
`define TWBC_BITS_PER_BYTE 4'h8
`endif

// ### hdl/twbc_shift.v
// byte shift register for the two-wire controller
// assumes shift and load strobes come from twbc_top on the same clock
`timescale 1ns/1ps
`include "twbc_regs.vh"
module twbc_shift (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire load,
    input wire [7:0] load_data,
    input wire shift,
    input wire shift_in,
    // result
    output reg [7:0] data_q
);
    // msb leaves first, received bits enter at lsb
    always @(posedge clk)
    begin
        if (rst)
            data_q <= 8'h00;
        else if (load)
            data_q <= load_data;
        else if (shift)
            data_q <= {data_q[6:0], shift_in};
    end
endmodule // twbc_shift

// ### tb/twbc_assertions.sv
// port checker for the two-wire bus controller
// assumes a bind onto twbc_top from the bench; rst is synchronous
`timescale 1ns/1ps
module twbc_assertions (
    // clock and reset
    input wire clk,
    input wire rst,
    // core side
    input wire bus_interface_enable,
    input wire pin_latch_sda,
    input wire pin_latch_scl,
    input wire mst_start,
    input wire byte_done_q,
    input wire bus_busy_q,
    input wire mst_active_q,
    // pins
    input wire serial_data_pin_i,
    input wire serial_data_pin_o,
    input wire serial_data_pin_oe,
    input wire serial_clock_pin_i,
    input wire serial_clock_pin_o,
    input wire serial_clock_pin_oe
);
// ==================================================
// properties
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
chk_pin_out_low: assert property (!serial_data_pin_o && !serial_clock_pin_o)
    else $error("pad output value not low");
chk_idle_no_drive: assert property ((!bus_busy_q && !mst_active_q
    && !$past(mst_active_q) && pin_latch_sda && pin_latch_scl)
    |-> !serial_data_pin_oe && !serial_clock_pin_oe)
    else $error("line driven while idle");
chk_latch_forces: assert property (!pin_latch_sda [*3] |-> serial_data_pin_oe)
    else $error("cleared latch left data line free");
chk_busy_no_start: assert property ((bus_busy_q && !mst_active_q && mst_start)
    |=> !mst_active_q)
    else $error("master began on busy bus");
chk_done_one_cycle: assert property (byte_done_q |=> !byte_done_q)
    else $error("byte done longer than one cycle");
chk_start_cond: assert property ($rose(mst_active_q) |-> ##[1:300]
    (serial_data_pin_oe && !serial_clock_pin_oe))
    else $error("no start after master begin");
chk_stretch_wait: assert property ((mst_active_q && !serial_clock_pin_oe
    && !serial_clock_pin_i) |=> !serial_clock_pin_oe)
    else $error("master pulled clock while held low");
chk_busy_on_start: assert property (($past(serial_clock_pin_i)
    && serial_clock_pin_i && $fell(serial_data_pin_i) && bus_interface_enable)
    |-> ##[1:4] bus_busy_q)
    else $error("start not seen as busy");
chk_free_on_stop: assert property (($past(serial_clock_pin_i)
    && serial_clock_pin_i && $rose(serial_data_pin_i) && bus_interface_enable)
    |-> ##[1:4] !bus_busy_q)
    else $error("stop not seen as free");
chk_free_start: assert property ((mst_start && !bus_busy_q && !mst_active_q
    && bus_interface_enable && serial_data_pin_i && serial_clock_pin_i
    && $past(serial_data_pin_i, 2) && $past(serial_clock_pin_i, 2))
    |-> ##[1:3] mst_active_q)
    else $error("start refused on free bus");
endmodule // twbc_assertions

// ### tb/twbc_slave_model.sv
// behavioural slave on the two-wire bus, write only
// assumes resolved open-drain lines; stretch in clk cycles, 0 for none
`timescale 1ns/1ps
module twbc_slave_model #(
    parameter [6:0] ADDR = 7'h5a
) (
    // bus
    input wire clk,
    input wire sda,
    input wire scl,
    input wire [7:0] stretch,
    output reg sda_lo,
    output reg scl_lo,
    // record
    output reg [7:0] last_byte,
    output reg [7:0] nbytes
);
// ==================================================
// receiver
reg [3:0] cnt;
reg [7:0] sh;
reg sel, first;
initial
begin
    {sda_lo, scl_lo, sel, first, cnt, sh, last_byte, nbytes} = 0;
end
always @(negedge sda) if (scl) {cnt, first, sel} = {4'h0, 2'b10};
always @(posedge sda) if (scl) {first, sel} = 2'b00;
always @(posedge scl) if (cnt < 8) {sh, cnt} = {sh[6:0], sda, cnt + 4'h1};
always @(negedge scl)
begin
    if (cnt == 8)
    begin
        if (first)
            sel = (sh[7:1] == ADDR) && !sh[0];
        else if (sel)
            {last_byte, nbytes} = {sh, nbytes + 8'h01};
        first = 0;
        sda_lo = sel;
        cnt = 9;
    end
    else if (cnt == 9)
    begin
        sda_lo = 0;
        cnt = 0;
        // stretching blocks this process, harmless as scl stays low
        if (sel && stretch != 0)
        begin
            scl_lo = 1;
            repeat (stretch) @(posedge clk);
            scl_lo = 0;
        end
    end
end
endmodule // twbc_slave_model

// ### tb/twbc_top_bench.sv
// bench for the two-wire bus controller: slave, master and busy cases
// assumes twbc_top, the slave model and the checker compile first
`timescale 1ns/1ps
module twbc_top_bench;
// ==================================================
// signals
reg clk, rst, en, fast, lat_sda, lat_scl, mst_start, mst_stop, mst_read;
reg tx_ack, cpu_ready, m_sda_lo, m_scl_lo, m_d;
reg [7:0] own, tx_data, stretch;
reg [6:0] mst_addr;
wire [7:0] rx_data_q, s_last, s_cnt;
wire byte_done_q, ack_rx_q, addr_match_q, arb_lost_q, bus_busy_q;
wire mst_active_q, sda_oe, scl_oe, s_sda_lo, s_scl_lo;
wire sda_w = !(sda_oe || s_sda_lo || m_sda_lo);
wire scl_w = !(scl_oe || s_scl_lo || m_scl_lo);
integer error_cnt, checks_done;
twbc_top dut (.clk(clk), .rst(rst), .bus_interface_enable(en),
    .own_address_register(own), .fast_mode(fast), .pin_latch_sda(lat_sda),
    .pin_latch_scl(lat_scl), .mst_start(mst_start), .mst_stop(mst_stop),
    .mst_addr(mst_addr), .mst_read(mst_read), .tx_data(tx_data),
    .tx_ack(tx_ack), .cpu_ready(cpu_ready), .rx_data_q(rx_data_q),
    .byte_done_q(byte_done_q), .ack_rx_q(ack_rx_q),
    .addr_match_q(addr_match_q), .slave_tx_q(), .arb_lost_q(arb_lost_q),
    .bus_busy_q(bus_busy_q), .mst_active_q(mst_active_q),
    .serial_data_pin_i(sda_w), .serial_data_pin_o(),
    .serial_data_pin_oe(sda_oe), .serial_clock_pin_i(scl_w),
    .serial_clock_pin_o(), .serial_clock_pin_oe(scl_oe));
twbc_slave_model slv (.clk(clk), .sda(sda_w), .scl(scl_w),
    .stretch(stretch), .sda_lo(s_sda_lo), .scl_lo(s_scl_lo),
    .last_byte(s_last), .nbytes(s_cnt));
// ==================================================
// shared tasks
task cmp(input [7:0] got, input [7:0] exp);
begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
end
endtask
task finish_test;
begin
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
end
endtask
task drv(input d, input c, input integer n);
begin
    @(posedge clk);
    m_sda_lo <= !d;
    m_scl_lo <= !c;
    repeat (n - 1) @(posedge clk);
end
endtask
// one bit at 140 ns, waiting out any stretch
task lbit(input b, output s);
    integer i;
begin
    drv(m_d, 0, 2);
    drv(b, 0, 2);
    drv(b, 1, 3);
    i = 0;
    while (!scl_w && i < 4000)
    begin
        @(negedge clk);
        i = i + 1;
    end
    @(negedge clk);
    s = sda_w;
    m_d = b;
end
endtask
task lbyte(input [7:0] v, output ack);
    integer k;
    reg s;
begin
    for (k = 7; k >= 0; k = k - 1)
        lbit(v[k], s);
    lbit(1'b1, s);
    ack = !s;
end
endtask
task lstart;
begin
    drv(1, 1, 4);
    drv(0, 1, 4);
    m_d = 0;
end
endtask
task lstop;
begin
    drv(m_d, 0, 2);
    drv(0, 0, 2);
    drv(0, 1, 4);
    drv(1, 1, 4);
    m_d = 1;
end
endtask
task wait_done(input idle);
    integer i;
begin
    i = 0;
    while ((idle ? (mst_active_q || bus_busy_q) : !byte_done_q) && i < 20000)
    begin
        @(negedge clk);
        i = i + 1;
    end
    cmp({7'h0, i < 20000}, 8'h01);
end
endtask
// ==================================================
// scenarios
task t_slave;
    integer i;
    reg [35:0] tab;
    reg [8:0] c;
    reg ack;
begin
    tab = {7'h3d, 2'b10, 7'h00, 2'b00, 7'h00, 2'b11, 7'h3c, 2'b01};
    for (i = 0; i < 4; i = i + 1)
    begin
        c = tab[i * 9 +: 9];
        @(posedge clk);
        own <= {7'h3c, c[1]};
        lstart;
        lbyte({c[8:2], 1'b0}, ack);
        cmp({7'h0, ack}, {7'h0, c[0]});
        cmp({7'h0, addr_match_q}, {7'h0, c[0]});
        lbyte(8'ha5, ack);
        cmp({7'h0, ack}, {7'h0, c[0]});
        if (c[0])
            cmp(rx_data_q, 8'ha5);
        lstop;
    end
    // slave transmit: read one byte, then nack it
    @(posedge clk);
    own <= 8'h78;
    tx_data <= 8'h96;
    lstart;
    lbyte(8'h79, ack);
    cmp({7'h0, ack}, 8'h01);
    for (i = 7; i >= 0; i = i - 1)
    begin
        lbit(1'b1, ack);
        c[i] = ack;
    end
    lbit(1'b1, ack);
    cmp(c[7:0], 8'h96);
    lstop;
    $display("slave receive test done");
end
endtask
task t_master;
    integer k;
    reg [7:0] n0;
begin
    for (k = 0; k < 2; k = k + 1)
    begin
        n0 = s_cnt;
        @(posedge clk);
        fast <= (k == 0);
        mst_addr <= k ? 7'h5b : 7'h5a;
        tx_data <= 8'hc3;
        cpu_ready <= 1'b0;
        mst_start <= 1'b1;
        @(posedge clk);
        mst_start <= 1'b0;
        wait_done(0);
        cmp({7'h0, ack_rx_q}, {7'h0, k == 0});
        if (k == 0)
        begin
            @(posedge clk);
            cpu_ready <= 1'b1;
            @(posedge clk);
            cpu_ready <= 1'b0;
            wait_done(0);
            @(posedge clk);
            mst_stop <= 1'b1;
            @(posedge clk);
            mst_stop <= 1'b0;
            cmp(s_last, 8'hc3);
        end
        wait_done(1);
        cmp(s_cnt - n0, {7'h0, k == 0});
    end
    $display("master transmit test done");
end
endtask
task t_busy;
begin
    lstart;
    drv(0, 0, 4);
    mst_start <= 1'b1;
    @(posedge clk);
    mst_start <= 1'b0;
    lat_sda <= 1'b0;
    repeat (200) @(posedge clk);
    @(negedge clk);
    cmp({7'h0, mst_active_q}, 8'h00);
    cmp({7'h0, bus_busy_q}, 8'h01);
    cmp({7'h0, sda_oe}, 8'h01);
    @(posedge clk);
    lat_sda <= 1'b1;
    lstop;
    @(negedge clk);
    cmp({7'h0, bus_busy_q}, 8'h00);
    $display("busy bus test done");
end
endtask
// ==================================================
// clock, watchdog and main sequence
initial
begin
    clk = 0;
    forever #10 clk = ~clk;
end
initial
begin
    repeat (60000) @(posedge clk);
    error_cnt = error_cnt + 1;
    $display("MISMATCH t=%0t watchdog expired", $time);
    finish_test;
end
initial
begin
    {error_cnt, checks_done} = 0;
    {rst, en, fast, lat_sda, lat_scl, tx_ack, cpu_ready, m_d} = 8'hff;
    {mst_start, mst_stop, mst_read, m_sda_lo, m_scl_lo} = 5'h00;
    {own, tx_data, mst_addr} = 23'h0;
    stretch = 8'h28;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_slave;
    t_master;
    t_busy;
    finish_test;
end
endmodule // twbc_top_bench
bind twbc_top twbc_assertions chk (.clk(clk), .rst(rst),
    .bus_interface_enable(bus_interface_enable),
    .pin_latch_sda(pin_latch_sda), .pin_latch_scl(pin_latch_scl),
    .mst_start(mst_start), .byte_done_q(byte_done_q),
    .bus_busy_q(bus_busy_q), .mst_active_q(mst_active_q),
    .serial_data_pin_i(serial_data_pin_i),
    .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe(serial_data_pin_oe),
    .serial_clock_pin_i(serial_clock_pin_i),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe(serial_clock_pin_oe));
